/* File: hdl/scsm_map.svh */
// Named constants for the self-check status monitor.
// Assumes inclusion by bare name from the design files.
`ifndef SCSM_MAP_SVH
`define SCSM_MAP_SVH

// Display unit codes
`define SCSM_PROCESS_VALUE_UNITS_CODE 4'h0
`define SCSM_ZERO_ERROR_CODE 4'h1
`define SCSM_SPAN_ERROR_CODE 4'h2
`define SCSM_SENSOR_ERROR_CODE 4'h3
`define SCSM_CABLE_ERROR_CODE 4'h4
`define SCSM_STATIC_RAM_ERROR_CODE 4'h5
`define SCSM_NONVOLATILE_ERROR_CODE 4'h6
`define SCSM_OPTION_BOARD_ERROR_CODE 4'h7
`define SCSM_CONVERTER_ERROR_CODE 4'h8
`define SCSM_SYSTEM_ZERO_ERROR_CODE 4'h9
`define SCSM_ZERO_CHECK_RUNNING_CODE 4'hA
`define SCSM_SPAN_CHECK_RUNNING_CODE 4'hB

// Counts
`define SCSM_NUM_ERR 9
`define SCSM_NUM_RELAY 2
`define SCSM_FAIL_RELAY_DEFAULT 1'h0

// Current-loop level commands: normal, 3.8 mA, 3.6 mA
`define SCSM_LOOP_NORMAL 2'h0
`define SCSM_LOOP_CHECK 2'h1
`define SCSM_LOOP_ERROR 2'h2

// Serial status word layout
`define SCSM_ST_ZERO_RUN 0
`define SCSM_ST_SPAN_RUN 1
`define SCSM_ST_SYSZ_RUN 2
`define SCSM_ST_PROBE_CABLE_ERR 3
`define SCSM_ST_ALARM 4
`define SCSM_ST_ERR_LSB 5

// Automatic check interval
`define SCSM_AUTO_INTERVAL_S 3600
`define SCSM_CLK_HZ 250000000
`define SCSM_TIMER_W 40

`endif

/* File: hdl/scsm_pkg.sv */
// Types of the self-check status monitor.
// Assumes scsm_map.svh for the widths it names.
`include "scsm_map.svh"

package scsm_pkg;

   typedef struct packed {
      logic run_meta;
      logic run_sync;
      logic cable_en;
      logic sensor_en;
      logic sysz_en;
      logic zero_start;
      logic span_start;
      logic suspend;
      logic [`SCSM_NUM_ERR-1:0] err;
      logic alarm;
      logic route;
      logic [`SCSM_NUM_RELAY-1:0] relay;
      logic [1:0] loop_level;
      logic [3:0] disp;
      logic [15:0] status;
   } scsm_state_type;

   typedef struct packed {
      logic [`SCSM_TIMER_W-1:0] count;
      logic expire;
   } scsm_timer_state_type;

endpackage : scsm_pkg

/* File: hdl/scsm_timer_if.sv */
// Handshake between the monitor and its interval timer.
// Assumes both ends share one clock.
`timescale 1ns/100ps

interface scsm_timer_if;
   logic arm;
   logic restart;
   logic expire;

   modport ctrl (output arm, output restart, input expire);
   modport timer (input arm, input restart, output expire);
endinterface : scsm_timer_if

/* File: hdl/scsm_interval_timer.sv */
// Resettable interval timer for periodic automatic self checks.
// Assumes the controller holds restart while any check runs.
`timescale 1ns/100ps
`include "scsm_map.svh"

module scsm_interval_timer #(
   parameter longint unsigned INTERVAL_CYCLES = 64'h0000_00D1_8C2E_2800
) (
   input wire logic clk_i,
   input wire logic reset_i,
   scsm_timer_if.timer tmr
);

   localparam logic [`SCSM_TIMER_W-1:0] LAST = `SCSM_TIMER_W'(INTERVAL_CYCLES - 64'h1);

   scsm_pkg::scsm_timer_state_type s_reg;
   scsm_pkg::scsm_timer_state_type s_next;

   // Count while armed; any restart or disarm starts the interval over
   always_comb begin
      s_next = s_reg;
      s_next.expire = 1'b0;
      if (tmr.restart || !tmr.arm) begin
         s_next.count = '0; // R19
      end else if (s_reg.count == LAST) begin
         s_next.count = '0;
         s_next.expire = 1'b1; // R19
      end else begin
         s_next.count = s_reg.count + `SCSM_TIMER_W'(1);
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tmr.expire = s_reg.expire;

endmodule : scsm_interval_timer

/* File: hdl/scsm_monitor.sv */
// Self-check status monitor: check gating, status codes, alarm relays,
// current-loop level commands and the serial status word.
// Assumes the check sequencer, display driver, loop DAC and network
// slave sit outside on the same clock; only the contact is asynchronous.
//
// What this block does
// R1: Cable check runs, paused during zero/span.
// R2: Sensor check runs, disabled during zero/span.
// R3: Cable check only with process running.
// R4: Closed fan contact means process running.
// R5: Process run input honoured only when enabled.
// R6: System zero offered when process input enabled.
// R7: Units shown only when idle and clean.
// R8: Zero and span running codes shown.
// R9: Numbered error codes one to nine.
// R10: Failed check energises assigned alarm relay.
// R11: Failure alarm latched until a pass.
// R12: Failure routed to relay one after reset.
// R13: Relay polarity normal or fail-safe.
// R14: Check level on loop when sensor disconnected during zero/span.
// R15: Error level on loop when error present.
// R16: Particulate alarms suspended while checks run.
// R17: Running flags and results readable serially.
// R18: Remote start bits; running and probe flags.
// R19: Interval timer starts checks, restarts on checks.
// R20: Error level beats check level.
// R21: Lowest numbered error shown first.
`timescale 1ns/100ps
`include "scsm_map.svh"

module scsm_monitor #(
   parameter longint unsigned AUTO_INTERVAL_CYCLES =
      64'(`SCSM_AUTO_INTERVAL_S) * 64'(`SCSM_CLK_HZ)
) (
   input wire logic clk_i,
   input wire logic reset_i,
   // Fan contact pin, closed = high
   input wire logic process_run_contact_i,
   // Configuration
   input wire logic process_run_enable_i,
   input wire logic auto_check_enable_i,
   input wire logic fail_relay_select_i,
   input wire logic [`SCSM_NUM_RELAY-1:0] relay_fail_safe_i,
   // Sequencer state
   input wire logic zero_check_running_i,
   input wire logic span_check_running_i,
   input wire logic system_zero_running_i,
   input wire logic sensor_disconnected_i,
   // Check results
   input wire logic result_valid_i,
   input wire logic [3:0] result_class_i,
   input wire logic result_pass_i,
   // Remote activation from the network slave
   input wire logic remote_zero_start_i,
   input wire logic remote_span_start_i,
   // Particulate level alarms
   input wire logic [`SCSM_NUM_RELAY-1:0] particulate_alarm_i,
   // Outputs
   output logic cable_check_enable_o,
   output logic sensor_check_enable_o,
   output logic system_zero_enable_o,
   output logic zero_start_o,
   output logic span_start_o,
   output logic particulate_alarm_suspend_o,
   output logic [`SCSM_NUM_RELAY-1:0] relay_drive_o,
   output logic [1:0] loop_level_o,
   output logic [3:0] process_value_units_field_o,
   output logic alarm_latched_o,
   output logic [15:0] status_word_o
);

   scsm_pkg::scsm_state_type s_reg;
   scsm_pkg::scsm_state_type s_next;

   logic zero_or_span;
   logic any_check;
   logic proc_run;
   logic class_ok;
   logic class_allowed;
   logic [3:0] class_idx;

   scsm_timer_if tmr ();

   // Interval timer for automatic checks
   scsm_interval_timer #(
      .INTERVAL_CYCLES(AUTO_INTERVAL_CYCLES)
   ) u_timer (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tmr(tmr)
   );

   // Timer runs only when automatic checks are configured
   assign tmr.arm = auto_check_enable_i;
   // Any running check, whatever started it, restarts the interval
   assign tmr.restart = any_check; // R19

   // Check activity summaries
   assign zero_or_span = zero_check_running_i | span_check_running_i;
   assign any_check = zero_or_span | system_zero_running_i;

   // Contact is only trusted after synchronising and when enabled
   assign proc_run = s_reg.run_sync & process_run_enable_i; // R4 R5

   // Result class decode: valid classes are one to nine
   assign class_ok = (result_class_i >= `SCSM_ZERO_ERROR_CODE) &&
                     (result_class_i <= `SCSM_SYSTEM_ZERO_ERROR_CODE);
   assign class_idx = result_class_i - 4'h1;

   // Continuous-check results only count while that check is live,
   // so a stale cable verdict from a stopped fan cannot latch an error
   always_comb begin
      unique case (result_class_i)
         `SCSM_SENSOR_ERROR_CODE: class_allowed = s_reg.sensor_en; // R2
         `SCSM_CABLE_ERROR_CODE: class_allowed = s_reg.cable_en; // R3
         `SCSM_SYSTEM_ZERO_ERROR_CODE: class_allowed = s_reg.sysz_en; // R6
         default: class_allowed = 1'b1;
      endcase
   end

   // Next-state logic for all monitor state
   always_comb begin
      s_next = s_reg;

      // Two-stage synchroniser for the fan contact
      s_next.run_meta = process_run_contact_i;
      s_next.run_sync = s_reg.run_meta;

      // Background checks pause while zero or span runs
      s_next.cable_en = proc_run & ~zero_or_span; // R1 R3
      s_next.sensor_en = ~zero_or_span; // R2
      // Whole-system zero needs the enabled process signal
      s_next.sysz_en = proc_run; // R6

      // Start pulses; requests during a running check are dropped
      s_next.zero_start = (remote_zero_start_i | tmr.expire) & ~any_check; // R18 R19
      s_next.span_start = (remote_span_start_i | tmr.expire) & ~any_check; // R18 R19

      // Level alarms are masked off while any check runs
      s_next.suspend = any_check; // R16

      // Results: failure sets its class and the alarm latch,
      // a pass clears its class and releases the latch
      if (result_valid_i && class_ok && class_allowed) begin
         if (result_pass_i) begin
            s_next.err[class_idx] = 1'b0;
            s_next.alarm = 1'b0; // R11
         end else begin
            s_next.err[class_idx] = 1'b1; // R9
            s_next.alarm = 1'b1; // R10
         end
      end

      // Failure relay selection, relay one from reset
      s_next.route = fail_relay_select_i; // R12

      // Relay drive with per-relay polarity
      for (int k = 0; k < `SCSM_NUM_RELAY; k++) begin
         s_next.relay[k] = ((particulate_alarm_i[k] & ~any_check) | // R16
                            (s_next.alarm & (s_reg.route == 1'(k)))) // R10 R12
                           ^ relay_fail_safe_i[k]; // R13
      end

      // Loop level: error outranks check in progress
      if (|s_next.err) begin
         s_next.loop_level = `SCSM_LOOP_ERROR; // R15 R20
      end else if (zero_or_span && sensor_disconnected_i) begin
         s_next.loop_level = `SCSM_LOOP_CHECK; // R14
      end else begin
         s_next.loop_level = `SCSM_LOOP_NORMAL;
      end

      // Display code: running codes, then lowest error, then units
      if (zero_check_running_i || system_zero_running_i) begin
         s_next.disp = `SCSM_ZERO_CHECK_RUNNING_CODE; // R8
      end else if (span_check_running_i) begin
         s_next.disp = `SCSM_SPAN_CHECK_RUNNING_CODE; // R8
      end else begin
         s_next.disp = `SCSM_PROCESS_VALUE_UNITS_CODE; // R7
         // Walk downward so the lowest set class wins
         for (int i = `SCSM_NUM_ERR - 1; i >= 0; i--) begin
            if (s_next.err[i]) begin
               s_next.disp = 4'(i + 1); // R9 R21
            end
         end
      end

      // Serial status word for the network slave
      s_next.status = '0;
      s_next.status[`SCSM_ST_ZERO_RUN] = zero_check_running_i; // R17 R18
      s_next.status[`SCSM_ST_SPAN_RUN] = span_check_running_i; // R17 R18
      s_next.status[`SCSM_ST_SYSZ_RUN] = system_zero_running_i; // R17
      s_next.status[`SCSM_ST_PROBE_CABLE_ERR] =
         s_next.err[`SCSM_SENSOR_ERROR_CODE - 4'h1] |
         s_next.err[`SCSM_CABLE_ERROR_CODE - 4'h1]; // R18
      s_next.status[`SCSM_ST_ALARM] = s_next.alarm; // R17
      s_next.status[`SCSM_ST_ERR_LSB +: `SCSM_NUM_ERR] = s_next.err; // R17
   end

   // State register; the alarm latch clears only by a pass or by reset,
   // and reset stands for loss of power
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s_reg <= '0;
         s_reg.route <= `SCSM_FAIL_RELAY_DEFAULT; // R12
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign cable_check_enable_o = s_reg.cable_en;
   assign sensor_check_enable_o = s_reg.sensor_en;
   assign system_zero_enable_o = s_reg.sysz_en;
   assign zero_start_o = s_reg.zero_start;
   assign span_start_o = s_reg.span_start;
   assign particulate_alarm_suspend_o = s_reg.suspend;
   assign relay_drive_o = s_reg.relay;
   assign loop_level_o = s_reg.loop_level;
   assign process_value_units_field_o = s_reg.disp;
   assign alarm_latched_o = s_reg.alarm;
   assign status_word_o = s_reg.status;

endmodule : scsm_monitor

/* File: test/scsm_monitor_assertions.sv */
// Port-level checks for the self-check status monitor.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`include "scsm_map.svh"

module scsm_monitor_assertions (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic process_run_contact_i,
   input wire logic process_run_enable_i,
   input wire logic zero_check_running_i,
   input wire logic span_check_running_i,
   input wire logic system_zero_running_i,
   input wire logic result_valid_i,
   input wire logic [3:0] result_class_i,
   input wire logic result_pass_i,
   input wire logic remote_zero_start_i,
   input wire logic cable_check_enable_o,
   input wire logic sensor_check_enable_o,
   input wire logic system_zero_enable_o,
   input wire logic zero_start_o,
   input wire logic particulate_alarm_suspend_o,
   input wire logic [1:0] loop_level_o,
   input wire logic [3:0] process_value_units_field_o,
   input wire logic alarm_latched_o,
   input wire logic [15:0] status_word_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Busy terms shared by several checks
   wire zs_busy = zero_check_running_i || span_check_running_i;
   wire any_busy = zs_busy || system_zero_running_i;

   // Contact must pass the two-stage synchroniser before it counts
   sequence s_run_held;
      (process_run_contact_i && process_run_enable_i && !zs_busy) [*3];
   endsequence
   sequence s_fail_taken;
      result_valid_i && !result_pass_i && result_class_i == 4'h1;
   endsequence

   a_cable_paused: assert property (zs_busy |=> !cable_check_enable_o)
      else $error("cable check enabled during a check");
   a_sensor_follows: assert property (1 |=> sensor_check_enable_o == !$past(zs_busy))
      else $error("sensor check enable wrong");
   a_contact_cable: assert property (s_run_held |=> cable_check_enable_o)
      else $error("cable check not enabled by held contact");
   a_channel_off: assert property (!process_run_enable_i |=> !cable_check_enable_o && !system_zero_enable_o)
      else $error("process run used while disabled");
   a_units_clean: assert property (process_value_units_field_o == `SCSM_PROCESS_VALUE_UNITS_CODE
      |-> status_word_o[13:0] == 14'h0000)
      else $error("units shown while busy or failed");
   a_zero_code: assert property (zero_check_running_i |=>
      process_value_units_field_o == `SCSM_ZERO_CHECK_RUNNING_CODE)
      else $error("zero running code missing");
   a_fail_latch: assert property (s_fail_taken |=> alarm_latched_o &&
      loop_level_o == `SCSM_LOOP_ERROR && status_word_o[`SCSM_ST_ERR_LSB])
      else $error("failure not latched");
   a_alarm_hold: assert property (alarm_latched_o && !(result_valid_i && result_pass_i) |=> alarm_latched_o)
      else $error("alarm cleared without a pass");
   a_suspend_busy: assert property (1 |=> particulate_alarm_suspend_o == $past(any_busy))
      else $error("suspend does not follow checks");
   a_remote_zero: assert property (remote_zero_start_i && !any_busy |=> zero_start_o)
      else $error("remote zero start lost");
endmodule : scsm_monitor_assertions

bind scsm_monitor scsm_monitor_assertions scsm_monitor_assertions_inst (.clk_i, .reset_i,
   .process_run_contact_i, .process_run_enable_i, .zero_check_running_i, .span_check_running_i,
   .system_zero_running_i, .result_valid_i, .result_class_i, .result_pass_i, .remote_zero_start_i,
   .cable_check_enable_o, .sensor_check_enable_o, .system_zero_enable_o, .zero_start_o,
   .particulate_alarm_suspend_o, .loop_level_o, .process_value_units_field_o, .alarm_latched_o,
   .status_word_o);

/* File: test/scsm_remote_master.sv */
// Remote master model: polls the status word and pulses activation bits.
// Assumes the bench calls fire from one process, one call at a time.
`timescale 1ns/100ps

module scsm_remote_master (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [15:0] status_word_i,
   output logic zero_start_o = 1'h0,
   output logic span_start_o = 1'h0
);
   logic [15:0] polled_status_reg;

   // Polls every cycle; a real master reads far less often
   always_ff @(posedge clk_i) begin
      polled_status_reg <= reset_i ? 16'h0000 : status_word_i;
   end

   // Writing one to an activation bit yields a single-cycle request
   task automatic fire(input logic z, input logic s);
      @(posedge clk_i);
      zero_start_o <= z;
      span_start_o <= s;
      @(posedge clk_i);
      zero_start_o <= 1'h0;
      span_start_o <= 1'h0;
   endtask : fire
endmodule : scsm_remote_master

/* File: test/scsm_monitor_bench.sv */
// Self-checking bench for the self-check status monitor.
// Assumes the design, the checker and the remote master model compile first.
`timescale 1ns/100ps
`include "scsm_map.svh"

module scsm_monitor_bench;
   logic clk_i = 1'h0, reset_i = 1'h1, contact = 1'h0, run_en = 1'h0, auto_en = 1'h0, sel = 1'h0;
   logic zr = 1'h0, sr = 1'h0, szr = 1'h0, disc = 1'h0, rv = 1'h0, rp = 1'h0;
   logic [1:0] fs = 2'h0, pa = 2'h0, rly, lvl;
   logic [3:0] rc = 4'h0, disp;
   logic rz, rs, cab, sen, sz, zs, ss, sus, alm;
   logic [15:0] st;
   int miscompares = 0, n_compared = 0, gap;

   // Short interval keeps the timer test brief
   scsm_monitor #(.AUTO_INTERVAL_CYCLES(64'h14)) scsm_monitor_inst (.clk_i(clk_i), .reset_i(reset_i),
      .process_run_contact_i(contact), .process_run_enable_i(run_en), .auto_check_enable_i(auto_en),
      .fail_relay_select_i(sel), .relay_fail_safe_i(fs), .zero_check_running_i(zr),
      .span_check_running_i(sr), .system_zero_running_i(szr), .sensor_disconnected_i(disc),
      .result_valid_i(rv), .result_class_i(rc), .result_pass_i(rp), .remote_zero_start_i(rz),
      .remote_span_start_i(rs), .particulate_alarm_i(pa), .cable_check_enable_o(cab),
      .sensor_check_enable_o(sen), .system_zero_enable_o(sz), .zero_start_o(zs), .span_start_o(ss),
      .particulate_alarm_suspend_o(sus), .relay_drive_o(rly), .loop_level_o(lvl),
      .process_value_units_field_o(disp), .alarm_latched_o(alm), .status_word_o(st));
   scsm_remote_master scsm_remote_master_inst (.clk_i(clk_i), .reset_i(reset_i), .status_word_i(st),
      .zero_start_o(rz), .span_start_o(rs));

   // 250 MHz clock
   initial forever #2 clk_i = ~clk_i;

   // Waits n edges, then lets their updates settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One result pulse; outputs are settled on return
   task automatic result(input logic [3:0] cls, input logic pass);
      @(posedge clk_i);
      rv <= 1'h1;
      rc <= cls;
      rp <= pass;
      cyc(1);
      rv <= 1'h0;
   endtask : result

   // Bounded wait for a start pulse, counting cycles
   task automatic wait_start(output int n);
      n = 0;
      while (zs !== 1'h1 && n < 60) begin
         cyc(1);
         n++;
      end
   endtask : wait_start

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   // Cuts a hang short well past the expected run length
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end

   initial begin
      cyc(16);
      reset_i <= 1'h0;
      cyc(1);
      zr <= 1'h1;
      disc <= 1'h1;
      cyc(2);
      chk("sensor_en", 16'h0, sen);
      chk("cable_en", 16'h0, cab);
      chk("suspend", 16'h1, sus);
      chk("display", `SCSM_ZERO_CHECK_RUNNING_CODE, disp);
      chk("loop", `SCSM_LOOP_CHECK, lvl);
      chk("status", 16'h0001, st);
      zr <= 1'h0;
      sr <= 1'h1;
      cyc(2);
      chk("display", `SCSM_SPAN_CHECK_RUNNING_CODE, disp);
      chk("polled", 16'h0002, scsm_remote_master_inst.polled_status_reg);
      sr <= 1'h0;
      disc <= 1'h0;
      $display("test gating done");
      // Closed contact is ignored until the channel is enabled
      contact <= 1'h1;
      cyc(5);
      chk("cable_en", 16'h0, cab);
      chk("sysz_en", 16'h0, sz);
      run_en <= 1'h1;
      cyc(2);
      chk("cable_en", 16'h1, cab);
      chk("sysz_en", 16'h1, sz);
      chk("sensor_en", 16'h1, sen);
      $display("test contact done");
      // Highest class first, so each new failure is the lowest shown
      for (int k = 9; k >= 1; k--) begin
         result(4'(k), 1'h0);
         chk("display", 16'(k), disp);
         chk("err_bit", 16'h1, st[4+k]);
      end
      chk("alarm", 16'h1, alm);
      chk("loop", `SCSM_LOOP_ERROR, lvl);
      chk("relay", 16'h1, rly);
      chk("probe_cable", 16'h1, st[`SCSM_ST_PROBE_CABLE_ERR]);
      fs <= 2'h3;
      zr <= 1'h1;
      disc <= 1'h1;
      cyc(2);
      chk("relay", 16'h2, rly);
      chk("loop", `SCSM_LOOP_ERROR, lvl);
      chk("alarm", 16'h1, alm);
      // Steering the failure to relay two leaves relay one idle
      sel <= 1'h1;
      cyc(2);
      chk("relay", 16'h1, rly);
      zr <= 1'h0;
      disc <= 1'h0;
      fs <= 2'h0;
      sel <= 1'h0;
      cyc(1);
      result(4'h1, 1'h1);
      chk("alarm", 16'h0, alm);
      chk("display", 16'h2, disp);
      for (int k = 2; k <= 9; k++) result(4'(k), 1'h1);
      chk("display", `SCSM_PROCESS_VALUE_UNITS_CODE, disp);
      chk("loop", `SCSM_LOOP_NORMAL, lvl);
      pa <= 2'h1;
      cyc(2);
      chk("relay", 16'h1, rly);
      zr <= 1'h1;
      cyc(2);
      chk("relay", 16'h0, rly);
      // Gated and unknown classes leave no trace while zero runs
      result(4'h4, 1'h0);
      result(4'h3, 1'h0);
      result(4'hC, 1'h0);
      chk("alarm", 16'h0, alm);
      chk("status", 16'h0001, st);
      $display("test errors done");
      // A start during a running check is dropped
      scsm_remote_master_inst.fire(1'h1, 1'h0);
      #1;
      chk("zero_start", 16'h0, zs);
      zr <= 1'h0;
      pa <= 2'h0;
      cyc(1);
      scsm_remote_master_inst.fire(1'h1, 1'h1);
      #1;
      chk("starts", 16'h3, {zs, ss});
      cyc(1);
      chk("starts", 16'h0, {zs, ss});
      $display("test remote done");
      // Timer fires after the interval and restarts while a check runs
      auto_en <= 1'h1;
      wait_start(gap);
      chk("interval", 16'h1, gap >= 19 && gap <= 25);
      chk("span_start", 16'h1, ss);
      zr <= 1'h1;
      cyc(30);
      zr <= 1'h0;
      wait_start(gap);
      chk("restart", 16'h1, gap >= 19 && gap <= 25);
      $display("test timer done");
      // Loss of power is the only other way to drop a latched failure
      result(4'h2, 1'h0);
      chk("alarm", 16'h1, alm);
      reset_i <= 1'h1;
      cyc(2);
      reset_i <= 1'h0;
      cyc(1);
      chk("alarm", 16'h0, alm);
      chk("display", `SCSM_PROCESS_VALUE_UNITS_CODE, disp);
      chk("loop", `SCSM_LOOP_NORMAL, lvl);
      $display("test power loss done");
      end_of_test();
   end
endmodule : scsm_monitor_bench
